/* rtl/dcscp_params.svh */
// dcscp_params.svh: bit positions and widths of the daisy-chain serial control port
// assumes: included by bare name from the design files of this block
`ifndef DCSCP_PARAMS_SVH
`define DCSCP_PARAMS_SVH

// --------------------------------------------------------------------
// serial framing
// --------------------------------------------------------------------
`define DCS_BIT_FIRST 3'h0
`define DCS_BIT_LAST 3'h7
`define DCS_IDX_BCAST 3'h0
`define DCS_IDX_RW 3'h1
`define DCS_IDX_CID0 3'h4
`define DCS_ADDR_W 6
`define DCS_DATA_W 8
`define DCS_IDLE_BYTE 8'hff

`endif

/* rtl/dcscp_pkg.sv */
// dcscp_pkg: types of the daisy-chain serial control port
// assumes: nothing beyond the compile order
package dcscp_pkg;

   // --------------------------------------------------------------------
   // byte phase of a transaction, gray coded along control-address-data
   // --------------------------------------------------------------------
   typedef enum logic [1:0] {
      DCSCP_PH_CTRL = 2'h0,
      DCSCP_PH_ADDR = 2'h1,
      DCSCP_PH_DATA = 2'h3,
      DCSCP_PH_DATA2 = 2'h2
   } dcscp_phase_t;

endpackage

/* rtl/dcscp_top.sv */
// dcscp_top: serial control port slave with chain forwarding and 8/16-bit autodetect
// assumes: SCLK_I, CS_N_I and SDI_I come from one controller and share its clock;
// the register file sits on CLOCK_I and answers a read in the cycle of REG_RD_O
`timescale 1ns/1ps
`include "dcscp_params.svh"

module dcscp_top (
   input wire logic CLOCK_I,
   input wire logic SYS_RST_I,
   input wire logic SCLK_I,
   input wire logic CS_N_I,
   input wire logic SDI_I,
   output logic SDO_O,
   output logic SDO_OE_O,
   output logic CHAIN_FORWARD_OUT_O,
   output logic REG_WR_O,
   output logic REG_RD_O,
   output logic [`DCS_ADDR_W-1:0] REG_ADDR_O,
   output logic [`DCS_DATA_W-1:0] REG_WDATA_O,
   input wire logic [`DCS_DATA_W-1:0] REG_RDATA_I,
   output logic MODE16_O
);

   // --------------------------------------------------------------------
   // link domain state
   // --------------------------------------------------------------------
   dcscp_pkg::dcscp_phase_t phase_r;
   dcscp_pkg::dcscp_phase_t phase_nxt;
   dcscp_pkg::dcscp_phase_t eff_phase;
   logic [2:0] bit_cnt_r;
   logic [2:0] eff_cnt;
   logic [6:0] sh_r;
   logic bcast_r;
   logic rw_r;
   logic borrow_r;
   logic cid_nz_r;
   logic fwd_pend_r;
   logic [`DCS_ADDR_W-1:0] addr_r;
   logic [`DCS_DATA_W-1:0] wdata_r;
   logic wr_req_t;
   logic rd_req_t;
   logic wide_r;
   logic cs_gap_r;
   logic [`DCS_DATA_W-1:0] tx_r;
   logic sdo_r;
   logic oe_r;
   logic ack_s1;
   logic ack_s2;

   // --------------------------------------------------------------------
   // system domain state
   // --------------------------------------------------------------------
   logic wr_s1;
   logic wr_s2;
   logic wr_s3;
   logic rd_s1;
   logic rd_s2;
   logic rd_s3;
   logic mode_s1;
   logic mode_s2;
   logic rd_ack_t;
   logic [`DCS_DATA_W-1:0] rd_hold_r;
   logic wr_r;
   logic rd_r;
   logic [`DCS_ADDR_W-1:0] reg_addr_r;
   logic [`DCS_DATA_W-1:0] reg_wdata_r;
   logic mode16_r;

   // --------------------------------------------------------------------
   // link decode
   // --------------------------------------------------------------------
   // a select gap that cuts a byte, or one after the data byte, starts afresh
   wire restart = cs_gap_r && (bit_cnt_r != `DCS_BIT_FIRST ||
                               phase_r == dcscp_pkg::DCSCP_PH_DATA2);
   assign eff_phase = restart ? dcscp_pkg::DCSCP_PH_CTRL : phase_r;
   assign eff_cnt = restart ? `DCS_BIT_FIRST : bit_cnt_r;
   wire byte_end = eff_cnt == `DCS_BIT_LAST;
   wire in_ctrl = eff_phase == dcscp_pkg::DCSCP_PH_CTRL;
   wire in_cid = in_ctrl && eff_cnt >= `DCS_IDX_CID0;
   wire [`DCS_DATA_W-1:0] rx_byte = {sh_r, SDI_I};
   wire wr_tgt = bcast_r || !cid_nz_r;
   wire rd_tgt = rw_r && !bcast_r && !cid_nz_r;
   // serial subtract by one, borrow ripples lsb first; broadcast starts with no borrow
   wire fwd_nxt = in_cid ? (SDI_I ^ borrow_r) : SDI_I;
   wire borrow_nxt = (in_ctrl && eff_cnt == `DCS_IDX_BCAST) ? !SDI_I :
                     in_cid ? (borrow_r && !SDI_I) : borrow_r;
   wire cid_nz_nxt = (in_ctrl && eff_cnt == `DCS_IDX_BCAST) ? 1'b0 :
                     in_cid ? (cid_nz_r || SDI_I) : cid_nz_r;
   wire wr_fire = eff_phase == dcscp_pkg::DCSCP_PH_DATA && byte_end && !rw_r
                  && wr_tgt;
   wire rd_fire = eff_phase == dcscp_pkg::DCSCP_PH_ADDR && byte_end && rd_tgt;
   wire addr_end = eff_phase == dcscp_pkg::DCSCP_PH_ADDR && byte_end;
   // decided afresh by every data byte; reads low through the first data byte of each access
   wire wide_nxt = (eff_phase == dcscp_pkg::DCSCP_PH_DATA2 && eff_cnt == `DCS_BIT_FIRST) ? 1'b1 :
                   (eff_phase == dcscp_pkg::DCSCP_PH_DATA && eff_cnt == `DCS_BIT_FIRST) ? 1'b0 :
                   wide_r;

   always_comb begin
      phase_nxt = eff_phase;
      if (byte_end) begin
         unique case (eff_phase)
            dcscp_pkg::DCSCP_PH_CTRL: phase_nxt = dcscp_pkg::DCSCP_PH_ADDR;
            dcscp_pkg::DCSCP_PH_ADDR: phase_nxt = dcscp_pkg::DCSCP_PH_DATA;
            dcscp_pkg::DCSCP_PH_DATA: phase_nxt = dcscp_pkg::DCSCP_PH_DATA2;
            dcscp_pkg::DCSCP_PH_DATA2: phase_nxt = dcscp_pkg::DCSCP_PH_CTRL;
         endcase
      end
   end

   // --------------------------------------------------------------------
   // link receive, sampled on the rising clock edge
   // --------------------------------------------------------------------
   always_ff @(posedge SCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         phase_r <= dcscp_pkg::DCSCP_PH_CTRL;
         bit_cnt_r <= `DCS_BIT_FIRST;
         sh_r <= 7'h00;
         fwd_pend_r <= 1'b0;
         borrow_r <= 1'b0;
         cid_nz_r <= 1'b1;
         wide_r <= 1'b0;
      end else if (!CS_N_I) begin
         phase_r <= phase_nxt;
         bit_cnt_r <= eff_cnt + 3'h1;
         sh_r <= rx_byte[6:0];
         fwd_pend_r <= fwd_nxt;
         borrow_r <= borrow_nxt;
         cid_nz_r <= cid_nz_nxt;
         wide_r <= wide_nxt;
      end
   end

   always_ff @(posedge SCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         bcast_r <= 1'b0;
         rw_r <= 1'b0;
         addr_r <= 6'h00;
         wdata_r <= 8'h00;
         wr_req_t <= 1'b0;
         rd_req_t <= 1'b0;
      end else if (!CS_N_I) begin
         if (in_ctrl && eff_cnt == `DCS_IDX_BCAST) bcast_r <= SDI_I;
         if (in_ctrl && eff_cnt == `DCS_IDX_RW) rw_r <= SDI_I;
         if (addr_end) addr_r <= rx_byte[`DCS_ADDR_W-1:0];
         if (wr_fire) wdata_r <= rx_byte;
         if (wr_fire) wr_req_t <= !wr_req_t;
         if (rd_fire) rd_req_t <= !rd_req_t;
      end
   end

   // select high marks a gap; with a burst clock there is no edge to see it, so it sets
   // asynchronously and the next rising edge under select clears it
   always_ff @(posedge SCLK_I or posedge SYS_RST_I or posedge CS_N_I) begin
      if (SYS_RST_I || CS_N_I) begin
         cs_gap_r <= 1'b1;
      end else begin
         cs_gap_r <= 1'b0;
      end
   end

   // --------------------------------------------------------------------
   // link transmit, launched on the falling clock edge
   // --------------------------------------------------------------------
   wire rd_ok = ack_s2 == rd_req_t;
   // a late answer sends idle ones instead of stale data
   wire [`DCS_DATA_W-1:0] load_byte = rd_ok ? rd_hold_r : `DCS_IDLE_BYTE;
   wire in_data = phase_r == dcscp_pkg::DCSCP_PH_DATA || phase_r == dcscp_pkg::DCSCP_PH_DATA2;
   wire drive_ok = !CS_N_I && rd_tgt && in_data && !restart;
   wire load_now = bit_cnt_r == `DCS_BIT_FIRST;

   always_ff @(negedge SCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         tx_r <= 8'h00;
         sdo_r <= 1'b0;
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
      end else begin
         ack_s1 <= rd_ack_t;
         ack_s2 <= ack_s1;
         if (drive_ok && load_now) begin
            sdo_r <= load_byte[`DCS_DATA_W-1];
            tx_r <= {load_byte[`DCS_DATA_W-2:0], 1'b0};
         end else if (drive_ok) begin
            sdo_r <= tx_r[`DCS_DATA_W-1];
            tx_r <= {tx_r[`DCS_DATA_W-2:0], 1'b0};
         end
      end
   end

   // output released at once when select rises, not at the next edge
   always_ff @(negedge SCLK_I or posedge SYS_RST_I or posedge CS_N_I) begin
      if (SYS_RST_I || CS_N_I) begin
         oe_r <= 1'b0;
      end else begin
         oe_r <= drive_ok;
      end
   end

   assign SDO_O = sdo_r;
   assign SDO_OE_O = oe_r;
   // the forwarded bit follows the input within the same bit time, so the next device
   // samples it on the same rising edge; a flop here would slip the chain one bit per device
   assign CHAIN_FORWARD_OUT_O = fwd_nxt;

   // --------------------------------------------------------------------
   // system side: toggle crossings and register strobes
   // --------------------------------------------------------------------
   // address and write data are held by the link side for a whole transaction,
   // far longer than the three system cycles the toggle takes to cross
   wire wr_evt = wr_s2 ^ wr_s3;
   wire rd_evt = rd_s2 ^ rd_s3;

   always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         wr_s1 <= 1'b0;
         wr_s2 <= 1'b0;
         wr_s3 <= 1'b0;
         rd_s1 <= 1'b0;
         rd_s2 <= 1'b0;
         rd_s3 <= 1'b0;
         mode_s1 <= 1'b0;
         mode_s2 <= 1'b0;
      end else begin
         wr_s1 <= wr_req_t;
         wr_s2 <= wr_s1;
         wr_s3 <= wr_s2;
         rd_s1 <= rd_req_t;
         rd_s2 <= rd_s1;
         rd_s3 <= rd_s2;
         mode_s1 <= wide_r;
         mode_s2 <= mode_s1;
      end
   end

   always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         reg_addr_r <= 6'h00;
         reg_wdata_r <= 8'h00;
         rd_hold_r <= 8'h00;
         rd_ack_t <= 1'b0;
         mode16_r <= 1'b0;
      end else begin
         wr_r <= wr_evt;
         rd_r <= rd_evt;
         mode16_r <= mode_s2;
         if (wr_evt || rd_evt) reg_addr_r <= addr_r;
         if (wr_evt) reg_wdata_r <= wdata_r;
         if (rd_r) rd_hold_r <= REG_RDATA_I;
         if (rd_r) rd_ack_t <= !rd_ack_t;
      end
   end

   assign REG_WR_O = wr_r;
   assign REG_RD_O = rd_r;
   assign REG_ADDR_O = reg_addr_r;
   assign REG_WDATA_O = reg_wdata_r;
   assign MODE16_O = mode16_r;

   // --------------------------------------------------------------------
   // checks
   // --------------------------------------------------------------------
   property p_oe_only_target;
      @(negedge SCLK_I) disable iff (SYS_RST_I)
      oe_r |-> (rw_r && !bcast_r && !cid_nz_r && !CS_N_I);
   endproperty
   a_oe_only_target: assert property (p_oe_only_target)
      else $error("data output enabled while not the read target");

   property p_head_unchanged;
      @(posedge SCLK_I) disable iff (SYS_RST_I)
      (!CS_N_I && in_ctrl && eff_cnt < `DCS_IDX_CID0) |=> fwd_pend_r == $past(SDI_I);
   endproperty
   a_head_unchanged: assert property (p_head_unchanged)
      else $error("broadcast or direction bit altered on forwarding");

   property p_bcast_id_passes;
      @(posedge SCLK_I) disable iff (SYS_RST_I)
      (!CS_N_I && in_cid && bcast_r) |=> fwd_pend_r == $past(SDI_I);
   endproperty
   a_bcast_id_passes: assert property (p_bcast_id_passes)
      else $error("broadcast channel id was decremented");

   property p_id_zero_borrows;
      @(posedge SCLK_I) disable iff (SYS_RST_I)
      (!CS_N_I && in_ctrl && eff_cnt == `DCS_IDX_CID0 && !bcast_r && !SDI_I)
         |=> fwd_pend_r && borrow_r;
   endproperty
   a_id_zero_borrows: assert property (p_id_zero_borrows)
      else $error("decrement of a zero id bit did not borrow");

   property p_write_commit;
      @(posedge SCLK_I) disable iff (SYS_RST_I)
      (!CS_N_I && eff_phase == dcscp_pkg::DCSCP_PH_DATA && byte_end && !rw_r)
         |=> (wr_req_t != $past(wr_req_t)) == $past(bcast_r || !cid_nz_r);
   endproperty
   a_write_commit: assert property (p_write_commit)
      else $error("write committed by wrong device or lost by target");

   property p_tail_dropped;
      @(posedge SCLK_I) disable iff (SYS_RST_I)
      (!CS_N_I && eff_phase == dcscp_pkg::DCSCP_PH_DATA2) |=> $stable(wr_req_t);
   endproperty
   a_tail_dropped: assert property (p_tail_dropped)
      else $error("second half of a wide write was committed");

   property p_restart;
      @(posedge SCLK_I) disable iff (SYS_RST_I)
      (!CS_N_I && cs_gap_r && bit_cnt_r != `DCS_BIT_FIRST)
         |=> (bit_cnt_r == 3'h1 && phase_r == dcscp_pkg::DCSCP_PH_CTRL);
   endproperty
   a_restart: assert property (p_restart)
      else $error("cut byte did not restart the state machine");

   property p_addr_msb_first;
      @(posedge SCLK_I) disable iff (SYS_RST_I)
      (!CS_N_I && addr_end) |=> addr_r[0] == $past(SDI_I) && addr_r[5] == $past(sh_r[4]);
   endproperty
   a_addr_msb_first: assert property (p_addr_msb_first)
      else $error("address byte not taken msb first");

   property p_wide_detect;
      @(posedge SCLK_I) disable iff (SYS_RST_I)
      (!CS_N_I && !cs_gap_r && phase_r == dcscp_pkg::DCSCP_PH_DATA2
       && bit_cnt_r == `DCS_BIT_FIRST) |=> wide_r;
   endproperty
   a_wide_detect: assert property (p_wide_detect)
      else $error("continued data byte not seen as wide framing");

   property p_wr_strobe;
      @(posedge CLOCK_I) disable iff (SYS_RST_I)
      $changed(wr_s2) |=> REG_WR_O ##1 !REG_WR_O;
   endproperty
   a_wr_strobe: assert property (p_wr_strobe)
      else $error("write strobe missing or longer than one cycle");

endmodule // dcscp_top

/* tb/dcscp_host_model.sv */
// dcscp_host_model: serial controller that frames bytes or words for the control port
// assumes: sdo_i is the resolved data-out wire, pulled up while nobody drives it
`timescale 1ns/1ps

module dcscp_host_model (
   output logic sclk_o,
   output logic cs_n_o,
   output logic sdi_o,
   input wire logic sdo_i,
   input wire logic fwd_i
);
   // --------------------------------------------------------------------
   // frame: select low, n bits msb first, select high, then a running gap
   // --------------------------------------------------------------------
   // the gap keeps the clock running so the read handshake can settle
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      sdi_o = 1'b1;
   end

   task automatic frame(input logic [15:0] tx, input int nbits, input int gap,
                        output logic [15:0] rx, output logic [15:0] fw);
      int i;
      rx = 16'h0000;
      fw = 16'h0000;
      tx = tx << (16 - nbits);
      cs_n_o <= 1'b0;
      #16;
      for (i = 0; i < nbits + gap; i++) begin
         sclk_o <= 1'b0;
         // outside the frame the line toggles so no stale level passes for data
         sdi_o <= (i < nbits) ? tx[15] : ~sdi_o;
         tx = tx << 1;
         #16;
         if (i < nbits) rx = {rx[14:0], sdo_i};
         if (i < nbits) fw = {fw[14:0], fwd_i};
         sclk_o <= 1'b1;
         #8;
         if (i == nbits - 1) cs_n_o <= 1'b1;
         #8;
      end
   endtask
endmodule // dcscp_host_model

/* tb/tb.sv */
// tb: random and corner transactions through a two-device chain on the control port
// assumes: the design and the host model are compiled first
`timescale 1ns/1ps
`include "dcscp_params.svh"

module tb;
   logic clk;
   logic rst;
   wire sclk;
   wire cs_n;
   wire sdi;
   wire sdo_w;
   logic [1:0] sdo, oe, fwd, wr, rd, m16, sdi_d, oe_seen;
   logic [`DCS_ADDR_W-1:0] addr [2];
   logic [`DCS_DATA_W-1:0] wdata [2];
   logic [`DCS_DATA_W-1:0] rdata [2];
   logic [`DCS_ADDR_W-1:0] wr_a [2];
   logic [`DCS_DATA_W-1:0] wr_d [2];
   logic [15:0] rx, fw;
   int wr_n [2];
   int rd_n [2];
   int n_mismatch, tests_run, cyc, t, r;
   int gap_n;
   logic host_rel;

   function automatic logic [7:0] rd_pat(input logic k, input logic [5:0] a);
      return {a, 1'b0, k} ^ 8'h96;
   endfunction

   // --------------------------------------------------------------------
   // chain of two devices, pulled-up shared data-out wire
   // --------------------------------------------------------------------
   // host_rel: the host releases the shared data line and sees the device output there
   assign sdi_d = {fwd[0], host_rel ? sdo_w : sdi};
   assign sdo_w = oe[0] ? sdo[0] : (oe[1] ? sdo[1] : 1'b1);
   for (genvar k = 0; k < 2; k++) begin : g_dev
      assign rdata[k] = rd_pat(1'(k), addr[k]);
      dcscp_top u_dut (.CLOCK_I(clk), .SYS_RST_I(rst), .SCLK_I(sclk), .CS_N_I(cs_n),
         .SDI_I(sdi_d[k]), .SDO_O(sdo[k]), .SDO_OE_O(oe[k]), .CHAIN_FORWARD_OUT_O(fwd[k]),
         .REG_WR_O(wr[k]), .REG_RD_O(rd[k]), .REG_ADDR_O(addr[k]), .REG_WDATA_O(wdata[k]),
         .REG_RDATA_I(rdata[k]), .MODE16_O(m16[k]));
   end
   dcscp_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_w),
      .fwd_i(fwd[0]));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // --------------------------------------------------------------------
   // register-side log and hang guard
   // --------------------------------------------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      oe_seen <= oe_seen | oe;
      for (int k = 0; k < 2; k++) begin
         if (wr[k] === 1'b1) begin
            wr_n[k]++;
            wr_a[k] <= addr[k];
            wr_d[k] <= wdata[k];
         end
         if (rd[k] === 1'b1) rd_n[k]++;
      end
      if (cyc == 8000) begin
         n_mismatch++;
         test_done;
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic access(input logic w16, input logic bc, input logic rw, input logic [3:0] id,
                         input logic [7:0] a, input logic [7:0] d, input logic [7:0] d2);
      logic [7:0] ctrl, fctl, v;
      logic [3:0] ids;
      logic [1:0] hit;
      int n0 [2];
      int r0 [2];
      ctrl = {bc, rw, 2'b10, id[0], id[1], id[2], id[3]};
      ids = bc ? id : id - 4'h1;
      hit = {bc | (id == 4'h1), bc | (id == 4'h0)};
      n0 = wr_n;
      r0 = rd_n;
      oe_seen = 2'b00;
      if (w16) begin
         u_host.frame({ctrl, a}, 16, gap_n, rx, fw);
         fctl = fw[15:8];
         host_rel = rw;
         u_host.frame({d, d2}, 16, gap_n, rx, fw);
         host_rel = 1'b0;
      end else begin
         u_host.frame({8'h00, ctrl}, 8, gap_n, rx, fw);
         fctl = fw[7:0];
         u_host.frame({8'h00, a}, 8, gap_n, rx, fw);
         u_host.frame({8'h00, d}, 8, gap_n, rx, fw);
         rx = {8'h00, rx[7:0]};
      end
      // after a burst-clock frame the crossings still need a few system cycles
      repeat (8) @(negedge clk);
      chk("forwarded control", {bc, rw, 2'b10, ids[0], ids[1], ids[2], ids[3]}, 16'(fctl));
      chk("framing mode", 16'({w16, w16}), 16'(m16));
      chk("output enables", 16'(rw ? hit : 2'b00), 16'(oe_seen));
      v = rd_pat(hit[1], a[5:0]);
      if (rw) chk("read data", hit != 2'b00 ? (w16 ? {v, v} : {8'h00, v}) : (w16 ? 16'hffff : 16'h00ff), rx);
      for (int k = 0; k < 2; k++) begin
         chk("write count", 16'(n0[k] + (rw ? 0 : int'(hit[k]))), 16'(wr_n[k]));
         chk("read count", 16'(r0[k] + (rw ? int'(hit[k]) : 0)), 16'(rd_n[k]));
         if (!rw && hit[k]) chk("write target", {2'b00, a[5:0], d}, {2'b00, wr_a[k], wr_d[k]});
      end
      t++;
      $display("test %0d done", t);
   endtask

   // --------------------------------------------------------------------
   // main sequence: corners first, then random accesses
   // --------------------------------------------------------------------
   initial begin
      rst = 1'b1;
      n_mismatch = 0;
      tests_run = 0;
      cyc = 0;
      t = 0;
      wr_n = '{0, 0};
      rd_n = '{0, 0};
      host_rel = 1'b0;
      gap_n = 40;
      oe_seen = 2'b00;
      r = $urandom(32'he213);
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      u_host.frame(16'h0005, 3, 40, rx, fw);
      access(1'b0, 1'b0, 1'b0, 4'h0, 8'hc5, 8'h3a, 8'h00);
      access(1'b1, 1'b1, 1'b0, 4'h0, 8'h7e, 8'ha1, 8'h5c);
      access(1'b1, 1'b0, 1'b1, 4'h1, 8'h3f, 8'h6d, 8'h92);
      access(1'b0, 1'b0, 1'b1, 4'hf, 8'h01, 8'hff, 8'h00);
      for (int i = 0; i < 24; i++) begin
         logic rw;
         rw = 1'($urandom);
         // even writes use a clock that stops between bytes; reads and odd writes keep it running
         gap_n = (rw || i[0]) ? 40 : 0;
         access(1'($urandom), ~rw & ($urandom % 4 == 0), rw, 4'($urandom % 4),
                8'($urandom), 8'($urandom), 8'($urandom));
      end
      test_done;
   end
endmodule // tb
